// File: hw/nvac_pkg.sv
package nvac_pkg;

    // ************************************************************
    // Register locations
    // ************************************************************
    localparam logic [7:0] ADDR_NV_ADDRESS = 8'h1E;
    localparam logic [7:0] ADDR_NV_DATA    = 8'h1F;
    localparam logic [7:0] ADDR_NV_CONTROL = 8'h40;
    localparam logic       BANK_CONTROL    = 1'h1;

    // ************************************************************
    // Field layout and sizes
    // ************************************************************
    localparam int DEPTH     = 64;
    localparam int AW        = 6;
    localparam int BIT_RD    = 0;
    localparam int BIT_READ_ENABLE_BIT  = 1;
    localparam int BIT_WR    = 2;
    localparam int BIT_WRITE_ENABLE_BIT  = 3;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ************************************************************
    // Timing in system cycles
    // ************************************************************
    localparam int RD_CYCLES = 2;
    localparam int WR_CYCLES = 40;
    localparam int CW        = 8;

    typedef enum logic [1:0] {
        NVAC_IDLE,
        NVAC_READ,
        NVAC_WRITE
    } nvac_state_t;

    // Register access from the core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nvac_req_t;

endpackage

// File: hw/nvac_ctrl.sv
`timescale 1ns/1ps
module nvac_ctrl #(
    parameter int RD_LAT = nvac_pkg::RD_CYCLES,
    parameter int WR_LAT = nvac_pkg::WR_CYCLES
) (
    input  wire logic               sys_clk_i,
    input  wire logic               rst_n_i,
    input  wire nvac_pkg::nvac_req_t req_i,
    input  wire logic               flag_clr_i,
    output logic [7:0]              rdata_o,
    output logic                    write_complete_flag_o,
    output logic                    busy_o
);

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0]            mem [nvac_pkg::DEPTH];
    logic [nvac_pkg::AW-1:0] nv_address, next_nv_address;
    logic [7:0]            nv_data, next_nv_data;
    logic [3:0]            nv_control, next_nv_control;
    logic                  flag, next_flag;
    logic [nvac_pkg::CW-1:0] cnt, next_cnt;
    nvac_pkg::nvac_state_t state, next_state;
    logic                  hit_a, hit_d, hit_c, mem_we;
    logic [7:0]            cwr;
    logic [7:0]            next_rdata;

    // Register decode
    always_comb begin
        hit_a = req_i.addr == nvac_pkg::ADDR_NV_ADDRESS;
        hit_d = req_i.addr == nvac_pkg::ADDR_NV_DATA;
        hit_c = req_i.addr == nvac_pkg::ADDR_NV_CONTROL &&
                req_i.bank == nvac_pkg::BANK_CONTROL;
        cwr   = req_i.wdata;
    end

    // Next state of registers and sequencer
    always_comb begin
        next_nv_address = nv_address;
        next_nv_data    = nv_data;
        next_nv_control = nv_control;
        next_flag       = flag;
        next_cnt        = cnt;
        next_state      = state;
        mem_we          = 1'b0;
        if (req_i.wr && hit_a) begin
            next_nv_address = cwr[nvac_pkg::AW-1:0];
        end
        if (req_i.wr && hit_d) begin
            next_nv_data = cwr;
        end
        if (flag_clr_i) begin
            next_flag = 1'b0;
        end
        case (state)
            nvac_pkg::NVAC_IDLE: begin
                if (req_i.wr && hit_c) begin
                    next_nv_control[nvac_pkg::BIT_WRITE_ENABLE_BIT] =
                        cwr[nvac_pkg::BIT_WRITE_ENABLE_BIT];
                    next_nv_control[nvac_pkg::BIT_READ_ENABLE_BIT] =
                        cwr[nvac_pkg::BIT_READ_ENABLE_BIT];
                    // Start bits need enable already set
                    next_nv_control[nvac_pkg::BIT_RD] =
                        cwr[nvac_pkg::BIT_RD] &&
                        nv_control[nvac_pkg::BIT_READ_ENABLE_BIT];
                    next_nv_control[nvac_pkg::BIT_WR] =
                        cwr[nvac_pkg::BIT_WR] &&
                        nv_control[nvac_pkg::BIT_WRITE_ENABLE_BIT];
                    if (next_nv_control[nvac_pkg::BIT_WR]) begin
                        next_state = nvac_pkg::NVAC_WRITE;
                        next_cnt   = nvac_pkg::CW'(WR_LAT - 1);
                    end else if (next_nv_control[nvac_pkg::BIT_RD]) begin
                        next_state = nvac_pkg::NVAC_READ;
                        next_cnt   = nvac_pkg::CW'(RD_LAT - 1);
                    end
                end
            end
            nvac_pkg::NVAC_READ: begin
                if (cnt == '0) begin
                    next_nv_data = mem[nv_address];
                    next_nv_control[nvac_pkg::BIT_RD] = 1'b0;
                    next_state = nvac_pkg::NVAC_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            nvac_pkg::NVAC_WRITE: begin
                // Internal timer paces the write
                if (cnt == '0) begin
                    mem_we = 1'b1;
                    next_nv_control[nvac_pkg::BIT_WR] = 1'b0;
                    next_flag  = 1'b1;   // Set wins over clear
                    next_state = nvac_pkg::NVAC_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: begin
                next_state = nvac_pkg::NVAC_IDLE;
            end
        endcase
    end

    // Register update
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nv_address <= '0;
            nv_data    <= nvac_pkg::RESET_BYTE;
            nv_control <= '0;
            flag       <= 1'b0;
            cnt        <= '0;
            state      <= nvac_pkg::NVAC_IDLE;
        end else begin
            nv_address <= next_nv_address;
            nv_data    <= next_nv_data;
            nv_control <= next_nv_control;
            flag       <= next_flag;
            cnt        <= next_cnt;
            state      <= next_state;
        end
    end

    // Store array, no reset
    always_ff @(posedge sys_clk_i) begin
        if (mem_we) begin
            mem[nv_address] <= nv_data;
        end
    end

    // Read data select, unmapped reads as zero
    always_comb begin
        next_rdata = '0;
        if (hit_a) begin
            next_rdata = {2'h0, nv_address};
        end else if (hit_d) begin
            next_rdata = nv_data;
        end else if (hit_c) begin
            next_rdata = {4'h0, nv_control};
        end
    end

    // Read data register
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    assign write_complete_flag_o = flag;
    assign busy_o = state != nvac_pkg::NVAC_IDLE;

    // ************************************************************
    // Checks
    // ************************************************************
    a_rd_needs_en: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        $rose(nv_control[nvac_pkg::BIT_RD]) |->
        $past(nv_control[nvac_pkg::BIT_READ_ENABLE_BIT]))
        else $error("read started without enable");
    a_wr_needs_en: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        $rose(nv_control[nvac_pkg::BIT_WR]) |->
        $past(nv_control[nvac_pkg::BIT_WRITE_ENABLE_BIT]))
        else $error("write started without enable");
    a_rd_clears: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        $rose(nv_control[nvac_pkg::BIT_RD]) |->
        ##[1:300] !nv_control[nvac_pkg::BIT_RD])
        else $error("read bit never cleared");
    a_wr_flag: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        $fell(nv_control[nvac_pkg::BIT_WR]) |-> flag)
        else $error("write end without flag");
    a_wr_clears: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        $rose(nv_control[nvac_pkg::BIT_WR]) |->
        ##[1:300] !nv_control[nvac_pkg::BIT_WR])
        else $error("write bit never cleared");
    a_addr_top: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        hit_a |=> rdata_o[7:6] == 2'h0)
        else $error("address top bits set");
    a_data_hold: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (state == nvac_pkg::NVAC_IDLE && !(req_i.wr && hit_d)) |=>
        nv_data == $past(nv_data))
        else $error("data changed while idle");
    a_ctrl_bank: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (req_i.wr && req_i.addr == nvac_pkg::ADDR_NV_CONTROL &&
         !req_i.bank && state == nvac_pkg::NVAC_IDLE) |=>
        nv_control == $past(nv_control))
        else $error("control written from bank 0");

    // ************************************************************
    // Cycle timing checks
    // ************************************************************
    // Counter loads on start
    a_rd_load: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        $rose(nv_control[nvac_pkg::BIT_RD]) |->
        (state == nvac_pkg::NVAC_READ && cnt == RD_LAT - 1))
        else $error("read cycle not loaded");
    a_wr_load: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        $rose(nv_control[nvac_pkg::BIT_WR]) |->
        (state == nvac_pkg::NVAC_WRITE && cnt == WR_LAT - 1))
        else $error("write cycle not loaded");
    // Timer steps down by one while busy
    a_cnt_down: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (state != nvac_pkg::NVAC_IDLE && cnt != '0) |=>
        cnt == $past(cnt) - 1'b1)
        else $error("timer did not step");

    // ************************************************************
    // Store transfer checks
    // ************************************************************
    a_wr_lands: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (state == nvac_pkg::NVAC_WRITE && cnt == '0) |=>
        mem[$past(nv_address)] == $past(nv_data))
        else $error("write byte not stored");
    a_rd_fetch: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (state == nvac_pkg::NVAC_READ && cnt == '0) |=>
        nv_data == $past(mem[nv_address]))
        else $error("read byte not fetched");
    // Enables frozen while a cycle runs
    a_busy_refuse: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (state != nvac_pkg::NVAC_IDLE && req_i.wr && hit_c) |=>
        (nv_control[nvac_pkg::BIT_WRITE_ENABLE_BIT] ==
         $past(nv_control[nvac_pkg::BIT_WRITE_ENABLE_BIT]) &&
         nv_control[nvac_pkg::BIT_READ_ENABLE_BIT] ==
         $past(nv_control[nvac_pkg::BIT_READ_ENABLE_BIT])))
        else $error("control taken while busy");

    // ************************************************************
    // Flag and register checks
    // ************************************************************
    a_flag_sticky: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (flag && !flag_clr_i) |=> flag)
        else $error("flag dropped by itself");
    a_flag_clear: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (flag_clr_i &&
         !(state == nvac_pkg::NVAC_WRITE && cnt == '0)) |=> !flag)
        else $error("flag not cleared");
    a_flag_source: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        $rose(flag) |-> $fell(nv_control[nvac_pkg::BIT_WR]))
        else $error("flag set without write end");
    a_addr_write: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (req_i.wr && hit_a) |=>
        nv_address == $past(req_i.wdata[nvac_pkg::AW-1:0]))
        else $error("address write lost");
    a_data_write: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (req_i.wr && hit_d && state == nvac_pkg::NVAC_IDLE) |=>
        nv_data == $past(req_i.wdata))
        else $error("data write lost");
    a_unmapped_zero: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (!hit_a && !hit_d && !hit_c) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        hit_c |=> rdata_o == {4'h0, $past(nv_control)})
        else $error("control readback wrong");
    a_data_readback: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        hit_d |=> rdata_o == $past(nv_data))
        else $error("data readback wrong");

endmodule // nvac_ctrl

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] A = nvac_pkg::ADDR_NV_ADDRESS;
    localparam logic [7:0] D = nvac_pkg::ADDR_NV_DATA;
    localparam logic [7:0] C = nvac_pkg::ADDR_NV_CONTROL;
    logic                sys_clk_i  = 1'b0;
    logic                rst_n_i    = 1'b0;
    nvac_pkg::nvac_req_t req_i      = '0;
    logic                flag_clr_i = 1'b0;
    logic [7:0]          rdata_o;
    logic                write_complete_flag_o;
    logic                busy_o;
    int                  fails      = 0;
    int                  num_checks = 0;
    int                  cycles     = 0;
    logic [7:0]          v;

    // Clock and hang guard
    always #20 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            tally_and_finish();
        end
    end

    nvac_ctrl nvac_ctrl_i (
        .sys_clk_i             (sys_clk_i),
        .rst_n_i               (rst_n_i),
        .req_i                 (req_i),
        .flag_clr_i            (flag_clr_i),
        .rdata_o               (rdata_o),
        .write_complete_flag_o (write_complete_flag_o),
        .busy_o                (busy_o)
    );

    // ********************************
    // Shared bus and compare tasks
    // ********************************
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic b, input logic [7:0] d);
        @(negedge sys_clk_i);
        req_i = '{wr: 1'b1, rd: 1'b0, bank: b, addr: a, wdata: d};
        @(negedge sys_clk_i);
        req_i.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic b, output logic [7:0] d);
        @(negedge sys_clk_i);
        req_i.addr = a;
        req_i.bank = b;
        @(negedge sys_clk_i);
        d = rdata_o;
    endtask

    // Busy must be seen and drop within the cycle budget
    task automatic wait_done(input string n, input int lat);
        int k;
        k = 0;
        while (busy_o === 1'b1 && k < 200) begin
            @(negedge sys_clk_i);
            k++;
        end
        chk(n, 8'h01, {7'h00, (k >= 1 && k <= lat && busy_o === 1'b0)});
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_reset();
        rd(A, 1'b0, v); chk("addr rst", 8'h00, v);
        rd(D, 1'b0, v); chk("data rst", 8'h00, v);
        rd(C, 1'b1, v); chk("ctrl rst", 8'h00, v);
        wr(A, 1'b0, 8'hFF);
        rd(A, 1'b0, v); chk("addr top", 8'h3F, v);
        wr(D, 1'b0, 8'hC3);
        rd(D, 1'b0, v); chk("data rw", 8'hC3, v);
    endtask

    task automatic t_refuse();
        wr(C, 1'b0, 8'h02);
        rd(C, 1'b1, v); chk("ctrl bank0", 8'h00, v);
        rd(C, 1'b0, v); chk("ctrl bank0 rd", 8'h00, v);
        wr(C, 1'b1, 8'h01);
        rd(C, 1'b1, v); chk("rd no en", 8'h00, v);
        chk("busy no en", 8'h00, {7'h00, busy_o});
        wr(C, 1'b1, 8'h04);
        rd(C, 1'b1, v); chk("wr no en", 8'h00, v);
        chk("flag no en", 8'h00, {7'h00, write_complete_flag_o});
    endtask

    task automatic t_write(input logic [7:0] a, input logic [7:0] d);
        wr(A, 1'b0, a);
        wr(D, 1'b0, d);
        wr(C, 1'b1, 8'h08);
        wr(C, 1'b1, 8'h0C);
        wait_done("wr time", nvac_pkg::WR_CYCLES);
        rd(C, 1'b1, v); chk("wr clr", 8'h08, v);
        chk("flag set", 8'h01, {7'h00, write_complete_flag_o});
        repeat (10) @(negedge sys_clk_i);
        chk("flag sticky", 8'h01, {7'h00, write_complete_flag_o});
        flag_clr_i = 1'b1;
        @(negedge sys_clk_i);
        flag_clr_i = 1'b0;
        @(negedge sys_clk_i);
        chk("flag clr", 8'h00, {7'h00, write_complete_flag_o});
    endtask

    task automatic t_read(input logic [7:0] a, input logic [7:0] d);
        wr(A, 1'b0, a);
        wr(D, 1'b0, 8'h00);
        wr(C, 1'b1, 8'h00);
        wr(C, 1'b1, 8'h02);
        wr(C, 1'b1, 8'h03);
        wait_done("rd time", nvac_pkg::RD_CYCLES);
        rd(C, 1'b1, v); chk("rd clr", 8'h02, v);
        rd(D, 1'b0, v); chk("rd data", d, v);
        repeat (8) @(negedge sys_clk_i);
        rd(D, 1'b0, v); chk("rd hold", d, v);
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        t_reset();
        t_refuse();
        t_write(8'h3F, 8'hA5);
        t_write(8'h00, 8'h5A);
        t_read(8'h3F, 8'hA5);
        t_read(8'h00, 8'h5A);
        tally_and_finish();
    end
endmodule // tb_top
